// ---- rlo_pkg.sv ----
// Package: offsets, reset values, field layout, types for the remote limit/offset/readout slice
package rlo_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] RD_RESULT_INT  = 8'h01;
  localparam logic [7:0] RD_UPPER_LIMIT = 8'h07;
  localparam logic [7:0] WR_UPPER_LIMIT = 8'h0d;
  localparam logic [7:0] RD_LOWER_LIMIT = 8'h08;
  localparam logic [7:0] WR_LOWER_LIMIT = 8'h0e;
  localparam logic [7:0] WR_ONESHOT     = 8'h0f;
  localparam logic [7:0] RD_RESULT_FRAC = 8'h10;
  localparam logic [7:0] RW_OFS_INT     = 8'h11;
  localparam logic [7:0] RW_OFS_FRAC    = 8'h12;

  // ----------------------------------------------------------------
  // Reset values and fields
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_UPPER_LIMIT = 8'h55;
  localparam logic [7:0] RST_LOWER_LIMIT = 8'h00;
  localparam logic [7:0] RST_OFS         = 8'h00;
  localparam logic [7:0] RST_RESULT      = 8'h00;
  localparam int         FRAC_MSB        = 7;
  localparam int         FRAC_LSB        = 4;
  localparam logic [7:0] FRAC_MASK       = 8'hf0;

  // Sixteenths of a degree; 64 degC bias of the extended format
  localparam logic signed [17:0] EXT_BIAS = 18'sh00400;
  localparam logic signed [17:0] STD_MAX  = 18'sh007ff;
  localparam logic signed [17:0] CODE_MAX = 18'sh00fff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CV_IDLE  = 2'b00,
    CV_RUN   = 2'b01,
    CV_STORE = 2'b11
  } rlo_cv_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } rlo_bus_t;

  typedef struct packed {
    rlo_cv_t    cv;
    logic       conv_start;
    logic       oneshot_pend;
    logic [7:0] upper_limit_bits;
    logic [7:0] lower_limit_bits;
    logic [7:0] offset_int_bits;
    logic [3:0] offset_fraction_bits;
    logic [7:0] result_int;
    logic [3:0] result_fraction_bits;
    logic [11:0] shadow;
    logic       lock_lo;
    logic       lock_hi;
    logic [7:0] rdata;
  } rlo_state_t;

endpackage : rlo_pkg

// ---- rlo_readout.sv ----
// Remote limit, offset and coherent result readout register slice
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// --------------------------------------------------------------------------------
// Overview of operation
// RULE1: Upper limit integer byte, read 07h, write 0Dh, resets to 55h.
// RULE2: Lower limit integer byte, read 08h, write 0Eh, resets to 00h.
// RULE3: In shutdown, any write to 0Fh starts exactly one conversion; not readable.
// RULE4: Result fraction byte read-only, bits 7..4 sixteenths, refreshed each conversion.
// RULE5: Reading result high byte first locks low byte until it is read.
// RULE6: Reading result low byte first locks high byte until it is read.
// RULE7: Any other register read ends the pairing lock.
// RULE8: Host should read high then low next; low may be skipped.
// RULE9: Offset integer byte read/write at 11h, resets to zero.
// RULE10: Offset fraction byte bits 7..4 read/write at 12h, resets to zero.
// RULE11: Offset added to every converter result before storing it.
// RULE12: Offset uses the result encoding, so negative offsets subtract.
// RULE13: Shutdown finishes the running conversion, then stops until cleared or one-shot.
// RULE14: Range bit high selects extended -64..191 degC format, else standard.
// RULE15: Low nibbles of fraction bytes read zero, writes to them ignored.
// --------------------------------------------------------------------------------
module rlo_readout
  import rlo_pkg::*;
#(
  parameter int RAW_W = 13
) (
  input  wire logic             core_clk,      // 20 MHz clock
  input  wire logic             rst_n,         // Async reset
  input  wire logic [7:0]       reg_addr,      // Register offset
  input  wire logic [7:0]       reg_wdata,     // Write data
  input  wire logic             reg_wr,        // Write strobe
  input  wire logic             reg_rd,        // Read strobe
  output logic      [7:0]       reg_rdata,     // Read data, cycle after strobe
  input  wire logic             shutdown_bit,  // Shutdown mode
  input  wire logic             range_sel,     // Extended format
  input  wire logic             rate_tick,     // Continuous start tick
  output logic                  conv_start,    // Conversion start pulse
  output logic                  conv_busy,     // Conversion in progress
  input  wire logic             conv_done,     // Conversion done pulse
  input  wire logic [RAW_W-1:0] conv_raw,      // Signed 1/16 degC
  output logic      [7:0]       upper_limit,   // Upper limit byte
  output logic      [7:0]       lower_limit,   // Lower limit byte
  output logic      [7:0]       result_int,    // Result high byte
  output logic      [7:0]       result_frac    // Result low byte
);
  import rlo_pkg::*;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (RAW_W < 12 || RAW_W > 16) begin : g_bad_raw
    $error("RAW_W must lie in 12..16");
  end

  // ----------------------------------------------------------------
  // Encoding helpers
  // ----------------------------------------------------------------
  function automatic logic signed [17:0] rlo_decode(input logic [11:0] code, input logic ext);
    logic signed [17:0] v;
    v = 18'(signed'(code));
    if (ext) begin
      v = signed'({6'h00, code}) - EXT_BIAS;
    end
    return v;
  endfunction : rlo_decode

  function automatic logic [11:0] rlo_encode(input logic signed [17:0] v, input logic ext);
    logic signed [17:0] c;
    logic signed [17:0] top;
    c   = ext ? v + EXT_BIAS : v;
    top = ext ? CODE_MAX : STD_MAX;
    // Saturate rather than wrap: a wrapped code would flip hot to cold
    if (c < 0) begin
      c = '0;
    end else if (c > top) begin
      c = top;
    end
    return c[11:0];
  endfunction : rlo_encode

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  rlo_state_t         q;
  rlo_state_t         next_q;
  rlo_bus_t           bus;
  logic signed [17:0] raw_ext;
  logic signed [17:0] sum;
  logic [11:0]        store_code;
  logic               oneshot_wr;
  logic               rd_int;
  logic               rd_frac;

  assign bus        = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
  assign oneshot_wr = bus.wr && bus.addr == WR_ONESHOT && shutdown_bit;       // RULE3
  assign rd_int     = bus.rd && bus.addr == RD_RESULT_INT;
  assign rd_frac    = bus.rd && bus.addr == RD_RESULT_FRAC;
  assign raw_ext    = 18'(signed'(conv_raw));
  // Offset joins the sum in the result's own encoding
  assign sum        = raw_ext + rlo_decode({q.offset_int_bits, q.offset_fraction_bits},
                                           range_sel);                        // RULE11 RULE12
  assign store_code = rlo_encode(sum, range_sel);                            // RULE14

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_q            = q;
    next_q.conv_start = 1'b0;

    // Register writes; read-only and unmapped offsets ignore writes
    if (bus.wr) begin
      case (bus.addr)
        WR_UPPER_LIMIT: begin
          next_q.upper_limit_bits = bus.wdata;                                // RULE1
        end
        WR_LOWER_LIMIT: begin
          next_q.lower_limit_bits = bus.wdata;                                // RULE2
        end
        RW_OFS_INT: begin
          next_q.offset_int_bits = bus.wdata;                                 // RULE9
        end
        RW_OFS_FRAC: begin
          next_q.offset_fraction_bits = bus.wdata[FRAC_MSB:FRAC_LSB];         // RULE10 RULE15
        end
        default: begin
        end
      endcase
    end

    // Register reads and the pairing lock
    if (bus.rd) begin
      case (bus.addr)
        RD_UPPER_LIMIT: begin
          next_q.rdata = q.upper_limit_bits;                                  // RULE1
        end
        RD_LOWER_LIMIT: begin
          next_q.rdata = q.lower_limit_bits;                                  // RULE2
        end
        RD_RESULT_INT: begin
          next_q.rdata = q.result_int;
        end
        RD_RESULT_FRAC: begin
          next_q.rdata = {q.result_fraction_bits, 4'h0};                      // RULE4 RULE15
        end
        RW_OFS_INT: begin
          next_q.rdata = q.offset_int_bits;                                   // RULE9
        end
        RW_OFS_FRAC: begin
          next_q.rdata = {q.offset_fraction_bits, 4'h0};                      // RULE10 RULE15
        end
        default: begin
          next_q.rdata = 8'h00;
        end
      endcase
      // Releasing a lock catches the byte up with the newest conversion
      if (q.lock_lo && !rd_int) begin
        next_q.lock_lo              = 1'b0;                                   // RULE5 RULE7
        next_q.result_fraction_bits = q.shadow[3:0];
      end
      if (q.lock_hi && !rd_frac) begin
        next_q.lock_hi    = 1'b0;                                             // RULE6 RULE7
        next_q.result_int = q.shadow[11:4];
      end
      if (rd_int && !q.lock_hi) begin
        next_q.lock_lo = 1'b1;                                                // RULE5
      end
      if (rd_frac && !q.lock_lo) begin
        next_q.lock_hi = 1'b1;                                                // RULE6
      end
    end

    // One-shot request waits if a conversion is already running
    if (oneshot_wr && q.cv != CV_IDLE) begin
      next_q.oneshot_pend = 1'b1;                                             // RULE3
    end

    // Conversion sequencing
    case (q.cv)
      CV_IDLE: begin
        if ((!shutdown_bit && rate_tick) || q.oneshot_pend || oneshot_wr) begin  // RULE3 RULE13
          next_q.cv           = CV_RUN;
          next_q.conv_start   = 1'b1;
          next_q.oneshot_pend = 1'b0;
        end
      end
      CV_RUN: begin
        // Shutdown does not abort: the running conversion completes
        if (conv_done) begin
          next_q.cv = CV_STORE;                                               // RULE13
        end
      end
      CV_STORE: begin
        next_q.cv     = CV_IDLE;
        next_q.shadow = store_code;                                           // RULE11
        // Locks taken this cycle already protect the paired byte
        if (!next_q.lock_hi) begin
          next_q.result_int = store_code[11:4];                               // RULE6
        end
        if (!next_q.lock_lo) begin
          next_q.result_fraction_bits = store_code[3:0];                      // RULE4 RULE5
        end
      end
      default: begin
        next_q.cv = CV_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      q                      <= '0;
      q.cv                   <= CV_IDLE;
      q.upper_limit_bits     <= RST_UPPER_LIMIT;                              // RULE1
      q.lower_limit_bits     <= RST_LOWER_LIMIT;                              // RULE2
      q.offset_int_bits      <= RST_OFS;                                      // RULE9
      q.offset_fraction_bits <= RST_OFS[FRAC_MSB:FRAC_LSB];                   // RULE10
      q.result_int           <= RST_RESULT;
      q.result_fraction_bits <= RST_RESULT[FRAC_MSB:FRAC_LSB];
    end else begin
      q <= next_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata   = q.rdata;
  assign conv_start  = q.conv_start;
  assign conv_busy   = q.cv != CV_IDLE;
  assign upper_limit = q.upper_limit_bits;
  assign lower_limit = q.lower_limit_bits;
  assign result_int  = q.result_int;
  assign result_frac = {q.result_fraction_bits, 4'h0};

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  AST_UPPER_WRITE: assert property (                                          // RULE1
    reg_wr && reg_addr == WR_UPPER_LIMIT |=> upper_limit == $past(reg_wdata))
    else $error("upper limit write not stored");

  AST_UPPER_READ: assert property (                                           // RULE1
    reg_rd && reg_addr == RD_UPPER_LIMIT |=> reg_rdata == $past(upper_limit))
    else $error("upper limit read wrong");

  AST_LOWER_WRITE: assert property (                                          // RULE2
    reg_wr && reg_addr == WR_LOWER_LIMIT ##1 reg_rd && reg_addr == RD_LOWER_LIMIT
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("lower limit write then read mismatch");

  AST_ONESHOT_START: assert property (                                        // RULE3
    reg_wr && reg_addr == WR_ONESHOT && shutdown_bit && !conv_busy |=> conv_start ##1 !conv_start)
    else $error("one-shot did not start one conversion");

  AST_SHUTDOWN_HOLD: assert property (                                        // RULE13
    shutdown_bit && !conv_busy && !q.oneshot_pend && !oneshot_wr |=> !conv_start)
    else $error("conversion started in shutdown");

  AST_FRAC_NIBBLE: assert property (                                          // RULE15
    reg_rd && (reg_addr == RD_RESULT_FRAC || reg_addr == RW_OFS_FRAC) |=> reg_rdata[3:0] == 4'h0)
    else $error("reserved nibble not zero");

  AST_LOCK_LOW: assert property (                                             // RULE5
    rd_int && !q.lock_hi ##1 !reg_rd |=> $stable(result_frac))
    else $error("low byte changed while locked");

  AST_LOCK_HIGH: assert property (                                            // RULE6
    rd_frac && !q.lock_lo ##1 !reg_rd |=> $stable(result_int))
    else $error("high byte changed while locked");

  AST_OTHER_READ: assert property (                                           // RULE7
    reg_rd && !rd_int && !rd_frac |=> !q.lock_lo && !q.lock_hi)
    else $error("lock survived another read");

  AST_OFS_FRAC: assert property (                                             // RULE10
    reg_wr && reg_addr == RW_OFS_FRAC |=> q.offset_fraction_bits == $past(reg_wdata[7:4]))
    else $error("offset fraction write lost");

  AST_STORE_SUM: assert property (                                            // RULE11 RULE12
    q.cv == CV_STORE && !reg_rd && !q.lock_lo && !q.lock_hi
    |=> {result_int, result_frac[7:4]} == $past(store_code))
    else $error("stored result is not raw plus offset");

  AST_UPPER_RO: assert property (                                             // RULE1
    reg_wr && reg_addr == RD_UPPER_LIMIT |=> $stable(upper_limit))
    else $error("write to upper limit read offset took effect");

  AST_LOWER_READ: assert property (                                           // RULE2
    reg_rd && reg_addr == RD_LOWER_LIMIT |=> reg_rdata == $past(lower_limit))
    else $error("lower limit read wrong");

  AST_LOWER_RO: assert property (                                             // RULE2
    reg_wr && reg_addr == RD_LOWER_LIMIT |=> $stable(lower_limit))
    else $error("write to lower limit read offset took effect");

  AST_NO_ONESHOT_READ: assert property (                                      // RULE3
    reg_rd && reg_addr == WR_ONESHOT |=> reg_rdata == 8'h00)
    else $error("one-shot offset returned data");

  AST_PEND_START: assert property (                                           // RULE3
    q.cv == CV_IDLE && q.oneshot_pend |=> conv_start)
    else $error("pending one-shot not started");

  AST_RESULT_RO: assert property (                                            // RULE4
    reg_wr && !reg_rd && q.cv != CV_STORE |=> $stable(result_int) && $stable(result_frac))
    else $error("register write changed the result");

  AST_CATCH_UP_LOW: assert property (                                         // RULE5 RULE7
    reg_rd && q.lock_lo && !rd_int && q.cv != CV_STORE |=> result_frac[7:4] == $past(q.shadow[3:0]))
    else $error("released low byte missed newest conversion");

  AST_CATCH_UP_HIGH: assert property (                                        // RULE6 RULE7
    reg_rd && q.lock_hi && !rd_frac && q.cv != CV_STORE |=> result_int == $past(q.shadow[11:4]))
    else $error("released high byte missed newest conversion");

  AST_OFS_INT_WRITE: assert property (                                        // RULE9
    reg_wr && reg_addr == RW_OFS_INT |=> q.offset_int_bits == $past(reg_wdata))
    else $error("offset integer write lost");

  AST_OFS_INT_READ: assert property (                                         // RULE9
    reg_rd && reg_addr == RW_OFS_INT |=> reg_rdata == $past(q.offset_int_bits))
    else $error("offset integer read wrong");

  AST_RUN_HOLD: assert property (                                             // RULE13
    q.cv == CV_RUN && shutdown_bit && !conv_done |=> conv_busy)
    else $error("shutdown aborted a running conversion");

  AST_STD_CEIL: assert property (                                             // RULE14
    q.cv == CV_STORE && !range_sel && !q.lock_hi && !reg_rd |=> !result_int[7])
    else $error("standard format result above its ceiling");

  COV_ONESHOT: cover property (oneshot_wr && !conv_busy ##1 conv_start);
  COV_HIGH_THEN_LOW: cover property (rd_int ##1 rd_frac);
  COV_LOW_FIRST: cover property (rd_frac ##1 q.cv == CV_STORE);
  COV_EXT_STORE: cover property (range_sel && q.cv == CV_STORE);
  COV_PENDING: cover property (oneshot_wr && conv_busy);

endmodule : rlo_readout

// ---- rlo_readout_tb.sv ----
// Self-checking testbench for the remote limit, offset and result readout slice
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module rlo_readout_tb;
  import rlo_pkg::*;
  // ----------------------------------------------------------------
  // Signals and design
  // ----------------------------------------------------------------
  typedef struct {int raw; logic [11:0] ofs; logic ext;} rlo_case_t;
  logic        core_clk, rst_n, reg_wr, reg_rd, shutdown_bit, range_sel, rate_tick, conv_done;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, upper_limit, lower_limit, result_int, result_frac;
  logic        conv_start, conv_busy;
  logic [12:0] conv_raw;
  int          bad_count, total_checks, cyc;
  rlo_case_t   cases [7];

  rlo_readout rlo_readout_inst (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shutdown_bit(shutdown_bit),
    .range_sel(range_sel), .rate_tick(rate_tick), .conv_start(conv_start), .conv_busy(conv_busy),
    .conv_done(conv_done), .conv_raw(conv_raw), .upper_limit(upper_limit), .lower_limit(lower_limit),
    .result_int(result_int), .result_frac(result_frac)
  );

  always #25 core_clk = ~core_clk;

  // Hang guard, far above the few hundred cycles the sequence needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : rd

  // Write strobe followed at once by a read strobe
  task automatic wr_rd(input logic [7:0] aw, input logic [7:0] d, input logic [7:0] ar, input logic [7:0] e);
    @(posedge core_clk);
    reg_wr <= 1'b1; reg_addr <= aw; reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0; reg_rd <= 1'b1; reg_addr <= ar;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask : wr_rd

  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge core_clk);
      #1 `CHK(conv_start, 1'b0)
    end
  endtask : quiet

  // Converter side: one done pulse, then a bounded wait for the store
  task automatic finish(input int raw);
    int k;
    @(posedge core_clk);
    conv_done <= 1'b1; conv_raw <= 13'(raw);
    @(posedge core_clk);
    conv_done <= 1'b0;
    #1;
    for (k = 0; k < 8 && conv_busy; k++) begin
      @(posedge core_clk);
      #1;
    end
    `CHK(conv_busy, 1'b0)
  endtask : finish

  task automatic conv(input int raw);
    wr(WR_ONESHOT, 8'hc3);
    `CHK(conv_start, 1'b1)
    finish(raw);
  endtask : conv

  task automatic chk_res(input logic [11:0] c);
    `CHK(result_int, c[11:4])
    `CHK(result_frac, {c[3:0], 4'h0})
    rd(RD_RESULT_INT, c[11:4]);
    rd(RD_RESULT_FRAC, {c[3:0], 4'h0});
  endtask : chk_res

  function automatic logic [11:0] expc(input int raw, input logic [11:0] ofs, input logic ext);
    int s;
    // Extended offset is biased like the result, so the two biases cancel
    s = raw + (ext ? int'(ofs) : int'($signed(ofs)));
    if (s < 0) s = 0;
    if (s > (ext ? 4095 : 2047)) s = ext ? 4095 : 2047;
    return s[11:0];
  endfunction : expc

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    core_clk = 0; rst_n = 0; reg_wr = 0; reg_rd = 0; reg_addr = 8'h00; reg_wdata = 8'h00;
    shutdown_bit = 1; range_sel = 0; rate_tick = 0; conv_done = 0; conv_raw = 13'h0000;
    cases = '{'{32'h191, 12'h028, 1'b0}, '{32'h100, 12'hff0, 1'b0}, '{32'h7f0, 12'h020, 1'b0},
              '{32'h010, 12'hfe0, 1'b0}, '{32'h190, 12'h400, 1'b1}, '{-1280, 12'h400, 1'b1},
              '{32'h100, 12'h3f8, 1'b1}};
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    #1 `CHK(upper_limit, 8'h55)
    `CHK(lower_limit, 8'h00)
    rd(RD_UPPER_LIMIT, 8'h55);
    rd(RD_LOWER_LIMIT, 8'h00);
    rd(RD_RESULT_FRAC, 8'h00);
    rd(RW_OFS_INT, 8'h00);
    rd(RW_OFS_FRAC, 8'h00);
    rd(WR_ONESHOT, 8'h00);
    rd(WR_UPPER_LIMIT, 8'h00);
    rd(WR_LOWER_LIMIT, 8'h00);
    // Write side and read-only places
    wr(WR_UPPER_LIMIT, 8'haa);
    `CHK(upper_limit, 8'haa)
    wr(RD_UPPER_LIMIT, 8'h11);
    rd(RD_UPPER_LIMIT, 8'haa);
    wr(WR_LOWER_LIMIT, 8'h66);
    wr_rd(WR_LOWER_LIMIT, 8'h33, RD_LOWER_LIMIT, 8'h33);
    wr(RD_LOWER_LIMIT, 8'h77);
    rd(RD_LOWER_LIMIT, 8'h33);
    `CHK(lower_limit, 8'h33)
    wr(RW_OFS_INT, 8'h5a);
    rd(RW_OFS_INT, 8'h5a);
    wr(RW_OFS_FRAC, 8'hff);
    rd(RW_OFS_FRAC, 8'hf0);
    wr(RD_RESULT_FRAC, 8'hff);
    rd(RD_RESULT_FRAC, 8'h00);
    rd(RD_UPPER_LIMIT, 8'haa);
    // Offset, sign and range table
    foreach (cases[i]) begin
      range_sel <= cases[i].ext;
      wr(RW_OFS_INT, cases[i].ofs[11:4]);
      wr(RW_OFS_FRAC, {cases[i].ofs[3:0], 4'h0});
      conv(cases[i].raw);
      chk_res(expc(cases[i].raw, cases[i].ofs, cases[i].ext));
    end
    range_sel <= 1'b0;
    wr(RW_OFS_INT, 8'h00);
    wr(RW_OFS_FRAC, 8'h00);
    conv(32'h123);
    quiet(4);
    // High byte first holds the low byte
    rd(RD_RESULT_INT, 8'h12);
    conv(32'h245);
    rd(RD_RESULT_FRAC, 8'h30);
    rd(RD_UPPER_LIMIT, 8'haa);
    conv(32'h367);
    // Low byte first holds the high byte
    rd(RD_RESULT_FRAC, 8'h70);
    conv(32'h489);
    rd(RD_RESULT_INT, 8'h36);
    rd(RD_UPPER_LIMIT, 8'haa);
    conv(32'h5ab);
    // A foreign read ends the pairing
    rd(RD_RESULT_INT, 8'h5a);
    conv(32'h6cd);
    rd(RD_LOWER_LIMIT, 8'h33);
    rd(RD_RESULT_FRAC, 8'hd0);
    rd(RD_UPPER_LIMIT, 8'haa);
    // One-shot written while busy runs once the first completes
    wr(WR_ONESHOT, 8'h5a);
    wr(WR_ONESHOT, 8'ha5);
    finish(32'h155);
    @(posedge core_clk);
    #1 `CHK(conv_start, 1'b1)
    finish(32'h166);
    chk_res(12'h166);
    quiet(3);
    // Continuous mode: one-shot ignored, rate tick starts
    shutdown_bit <= 1'b0;
    wr(WR_ONESHOT, 8'h00);
    quiet(3);
    @(posedge core_clk);
    rate_tick <= 1'b1;
    @(posedge core_clk);
    rate_tick <= 1'b0;
    #1 `CHK(conv_start, 1'b1)
    shutdown_bit <= 1'b1;
    finish(32'h211);
    chk_res(12'h211);
    @(posedge core_clk);
    rate_tick <= 1'b1;
    @(posedge core_clk);
    rate_tick <= 1'b0;
    quiet(3);
    complete_run();
  end
endmodule : rlo_readout_tb
